// ### hw/tsw_slave.sv
// Two-wire slave front end with temperature result and oscillator registers
//
// What this block does
// - Requests temperature conversions from reset onward and repeats them forever.
// - Result holds latest completed conversion; reads never disturb the converter.
// - Result byte 64h: sign and integer bits; byte 65h: two fraction bits.
// - Negative temperatures are two's complement across both bytes.
// - All bytes are shifted most significant bit first.
// - Command 64h returns high byte then low byte; master may stop after one.
// - Commands 5Dh, 60h, 66h access one byte of three control registers.
// - Register pointer never auto-increments; it is kept until the next command byte.
// - Device is slave only; master makes clock, START and STOP.
// - Works with serial clocks up to 100 kHz and 400 kHz.
// - Data-line change while clock is high is a control condition.
// - Data falling while clock high is a START.
// - Data rising while clock high is a STOP.
// - Data changes only with clock low; one clock pulse per bit.
// - Bytes of eight bits, each followed by a ninth acknowledge bit.
// - Receiver acknowledges by holding data low through the ninth clock high.
// - On master not-acknowledge the slave releases data high.
// - Address select pin picks one of two slave addresses.
// - First byte is 7-bit address plus direction; matching address acknowledged.
// - Every byte received from the master after a matching address is acknowledged.
`timescale 1ns/1ps
`include "tsw_defs.svh"

module tsw_slave (
	// Clock and reset
	input wire logic clk_sys_i,
	input wire logic rst_i,
	// Two-wire pins
	input wire logic scl_i,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe_o,
	input wire logic address_select_pin_i,
	// Temperature converter
	output logic conv_req_o,
	input wire logic conv_done_i,
	input wire logic [`TSW_TEMP_W-1:0] conv_data_i,
	// Register contents to the compensated_oscillator
	output logic [7:0] freq_sel_o,
	output logic [7:0] osc_ctrl_o,
	output logic [7:0] freq_tune_o
);

	logic [1:0] scl_sync_r;
	logic [1:0] sda_sync_r;
	logic [1:0] asel_sync_r;
	logic scl_d_r;
	logic sda_d_r;
	logic scl_rise;
	logic scl_fall;
	logic start_det;
	logic stop_det;

	tsw_pkg::tsw_state_t state_r;
	logic [3:0] bit_cnt_r;
	logic [7:0] rx_sh_r;
	logic [7:0] tx_sh_r;
	logic first_byte_r;
	logic rd_dir_r;
	logic wr_data_r;
	logic rd_second_r;
	logic mnack_r;
	logic [7:0] cmd_r;
	logic [7:0] rx_byte;
	logic [7:0] first_b;
	logic [7:0] second_b;
	logic wr_done_r;

	logic [`TSW_TEMP_W-1:0] temp_r;
	logic [`TSW_TEMP_W-1:0] snap_r;

	logic [7:0] freq_sel_r;
	logic [7:0] osc_ctrl_r;
	logic [7:0] freq_tune_r;
	logic sda_oe_r;
	logic conv_req_r;

	// Byte to send for a command; second marks the byte right after the first
	function automatic logic [7:0] rd_byte(
		input logic [7:0] cmd,
		input logic second,
		input logic [`TSW_TEMP_W-1:0] t
	);
		logic [7:0] b;
		b = `TSW_IDLE_BYTE;
		case (cmd)
			`TSW_CMD_FREQ_SEL: b = second ? `TSW_IDLE_BYTE : freq_sel_r;
			`TSW_CMD_OSC_CTRL: b = second ? `TSW_IDLE_BYTE : osc_ctrl_r;
			`TSW_CMD_FREQ_TUNE: b = second ? `TSW_IDLE_BYTE : freq_tune_r;
			`TSW_CMD_TEMP_HI: begin
				b = second ? {t[1:0], 6'h00} : t[`TSW_TEMP_W-1:2];
			end
			`TSW_CMD_TEMP_LO: b = second ? `TSW_IDLE_BYTE : {t[1:0], 6'h00};
			default: b = `TSW_IDLE_BYTE;
		endcase
		return b;
	endfunction

	// Bytes ready for the next load; always_comb also follows the registers the function reads
	always_comb begin
		first_b = rd_byte(cmd_r, 1'b0, temp_r);
		second_b = rd_byte(cmd_r, 1'b1, snap_r);
	end

	// Pin synchronisers; only the second stage is read by logic
	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			scl_sync_r <= 2'h3;
			sda_sync_r <= 2'h3;
			asel_sync_r <= 2'h0;
			scl_d_r <= 1'b1;
			sda_d_r <= 1'b1;
		end else begin
			scl_sync_r <= {scl_sync_r[0], scl_i};
			sda_sync_r <= {sda_sync_r[0], sda_i};
			asel_sync_r <= {asel_sync_r[0], address_select_pin_i};
			scl_d_r <= scl_sync_r[1];
			sda_d_r <= sda_sync_r[1];
		end
	end

	// 50 ns sampling leaves many samples per bit even at 400 kHz
	assign scl_rise = scl_sync_r[1] & ~scl_d_r;
	assign scl_fall = ~scl_sync_r[1] & scl_d_r;
	assign start_det = scl_sync_r[1] & scl_d_r & sda_d_r & ~sda_sync_r[1];
	assign stop_det = scl_sync_r[1] & scl_d_r & ~sda_d_r & sda_sync_r[1];
	assign rx_byte = rx_sh_r;

	// Conversion loop: request stays up, each completion is latched
	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			conv_req_r <= 1'b0;
			temp_r <= `TSW_RST_TEMP;
		end else begin
			conv_req_r <= 1'b1;
			if (conv_done_i) begin
				temp_r <= conv_data_i;
			end
		end
	end

	// Transfer state machine
	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			state_r <= tsw_pkg::ST_IDLE;
			bit_cnt_r <= 4'h0;
			rx_sh_r <= 8'h00;
			tx_sh_r <= 8'h00;
			first_byte_r <= 1'b0;
			rd_dir_r <= 1'b0;
			wr_data_r <= 1'b0;
			rd_second_r <= 1'b0;
			mnack_r <= 1'b0;
			wr_done_r <= 1'b0;
			sda_oe_r <= 1'b0;
		end else if (start_det) begin
			// Repeated START also lands here; pointer is kept
			state_r <= tsw_pkg::ST_RX;
			bit_cnt_r <= 4'h0;
			first_byte_r <= 1'b1;
			wr_data_r <= 1'b0;
			wr_done_r <= 1'b0;
			sda_oe_r <= 1'b0;
		end else if (stop_det) begin
			state_r <= tsw_pkg::ST_IDLE;
			sda_oe_r <= 1'b0;
		end else begin
			case (state_r)
				tsw_pkg::ST_IDLE: begin
					sda_oe_r <= 1'b0;
				end
				tsw_pkg::ST_RX: begin
					if (scl_rise) begin
						rx_sh_r <= {rx_sh_r[6:0], sda_sync_r[1]};
						bit_cnt_r <= bit_cnt_r + 4'h1;
					end else if (scl_fall && bit_cnt_r == 4'h8) begin
						bit_cnt_r <= 4'h0;
						if (first_byte_r) begin
							first_byte_r <= 1'b0;
							if (rx_byte[7:1] == {`TSW_ADDR_BASE, asel_sync_r[1]}) begin
								rd_dir_r <= rx_byte[0];
								sda_oe_r <= 1'b1;
								state_r <= tsw_pkg::ST_RX_ACK;
							end else begin
								state_r <= tsw_pkg::ST_WAIT;
							end
						end else begin
							wr_data_r <= 1'b1;
							wr_done_r <= wr_data_r;
							sda_oe_r <= 1'b1;
							state_r <= tsw_pkg::ST_RX_ACK;
						end
					end
				end
				tsw_pkg::ST_RX_ACK: begin
					// Low held from the eighth fall to the ninth fall
					if (scl_fall) begin
						bit_cnt_r <= 4'h0;
						if (rd_dir_r && !wr_data_r) begin
							tx_sh_r <= first_b;
							rd_second_r <= 1'b1;
							sda_oe_r <= ~first_b[7];
							state_r <= tsw_pkg::ST_TX;
						end else begin
							sda_oe_r <= 1'b0;
							state_r <= tsw_pkg::ST_RX;
						end
					end
				end
				tsw_pkg::ST_TX: begin
					if (scl_rise) begin
						bit_cnt_r <= bit_cnt_r + 4'h1;
					end else if (scl_fall) begin
						if (bit_cnt_r == 4'h8) begin
							sda_oe_r <= 1'b0;
							state_r <= tsw_pkg::ST_TX_MACK;
						end else begin
							tx_sh_r <= {tx_sh_r[6:0], 1'b0};
							sda_oe_r <= ~tx_sh_r[6];
						end
					end
				end
				tsw_pkg::ST_TX_MACK: begin
					if (scl_rise) begin
						mnack_r <= sda_sync_r[1];
					end else if (scl_fall) begin
						bit_cnt_r <= 4'h0;
						if (mnack_r) begin
							sda_oe_r <= 1'b0;
							state_r <= tsw_pkg::ST_WAIT;
						end else begin
							// No pointer step: extra bytes after the set are idle bytes
							tx_sh_r <= rd_second_r ? second_b : `TSW_IDLE_BYTE;
							sda_oe_r <= rd_second_r ? ~second_b[7] : 1'b0;
							rd_second_r <= 1'b0;
							state_r <= tsw_pkg::ST_TX;
						end
					end
				end
				tsw_pkg::ST_WAIT: begin
					sda_oe_r <= 1'b0;
				end
				default: begin
					state_r <= tsw_pkg::ST_IDLE;
					sda_oe_r <= 1'b0;
				end
			endcase
		end
	end

	// Snapshot at the first read byte keeps both temperature bytes coherent
	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			snap_r <= `TSW_RST_TEMP;
		end else if (state_r == tsw_pkg::ST_RX_ACK && scl_fall && rd_dir_r && !wr_data_r) begin
			snap_r <= temp_r;
		end
	end

	// Command pointer and register writes
	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			cmd_r <= `TSW_RST_CMD;
			freq_sel_r <= `TSW_RST_FREQ_SEL;
			osc_ctrl_r <= `TSW_RST_OSC_CTRL;
			freq_tune_r <= `TSW_RST_FREQ_TUNE;
		end else if (state_r == tsw_pkg::ST_RX && scl_fall && bit_cnt_r == 4'h8
			&& !first_byte_r) begin
			if (!wr_data_r) begin
				cmd_r <= rx_byte;
			end else if (!wr_done_r) begin
				// Only the first data byte of a write lands
				case (cmd_r)
					`TSW_CMD_FREQ_SEL: freq_sel_r <= rx_byte;
					`TSW_CMD_OSC_CTRL: osc_ctrl_r <= rx_byte;
					`TSW_CMD_FREQ_TUNE: freq_tune_r <= rx_byte;
					default: cmd_r <= cmd_r;
				endcase
			end
		end
	end

	// Open-drain data pin only ever pulls low
	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			sda_o <= 1'b0;
		end else begin
			sda_o <= 1'b0;
		end
	end

	assign sda_oe_o = sda_oe_r;
	assign conv_req_o = conv_req_r;
	assign freq_sel_o = freq_sel_r;
	assign osc_ctrl_o = osc_ctrl_r;
	assign freq_tune_o = freq_tune_r;

endmodule // tsw_slave

// ### hw/tsw_defs.svh
// Constants of the two-wire temperature slave
`ifndef TSW_DEFS_SVH
`define TSW_DEFS_SVH
`define TSW_CMD_FREQ_SEL 8'h5d
`define TSW_CMD_OSC_CTRL 8'h60
`define TSW_CMD_TEMP_HI 8'h64
`define TSW_CMD_TEMP_LO 8'h65
`define TSW_CMD_FREQ_TUNE 8'h66
`define TSW_RST_FREQ_SEL 8'h00
`define TSW_RST_OSC_CTRL 8'h00
`define TSW_RST_FREQ_TUNE 8'h00
`define TSW_RST_TEMP 10'h000
`define TSW_RST_CMD 8'h00
// Upper six bits of the slave address; arbitrary value
`define TSW_ADDR_BASE 6'h2a
`define TSW_TEMP_W 10
`define TSW_TEMP_FRAC_POS 6
`define TSW_IDLE_BYTE 8'hff
`endif

// ### hw/tsw_pkg.sv
// Types of the two-wire temperature slave
package tsw_pkg;
	typedef enum logic [2:0] {
		ST_IDLE,
		ST_RX,
		ST_RX_ACK,
		ST_TX,
		ST_TX_MACK,
		ST_WAIT
	} tsw_state_t;
endpackage

// ### tb/tsw_master_model.sv
// Two-wire bus master model
`timescale 1ns/1ps
module tsw_master_model (
	input wire logic clk_i,
	input wire logic sda_i,
	output logic scl_o,
	output logic sda_o
);
	initial begin
		scl_o = 1'b1;
		sda_o = 1'b1;
	end
	task automatic tk(input int n);
		repeat (n) @(negedge clk_i);
	endtask
	// Data moves mid-low, sampled at the end of high
	task automatic bit_io(input logic b, output logic r);
		scl_o = 1'b0;
		tk(2);
		sda_o = b;
		tk(2);
		scl_o = 1'b1;
		tk(4);
		r = sda_i;
	endtask
	// Data a then b with clock high: START if b low, STOP if b high
	task automatic cond(input logic a, input logic b);
		scl_o = 1'b0;
		tk(2);
		sda_o = a;
		tk(2);
		scl_o = 1'b1;
		tk(4);
		sda_o = b;
		tk(4);
	endtask
	task automatic xfer(input logic [7:0] d, input logic ak, output logic [7:0] q, output logic a);
		for (int i = 7; i >= 0; i--)
			bit_io(d[i], q[i]);
		bit_io(ak, a);
	endtask
endmodule // tsw_master_model

// ### tb/tsw_slave_assertions.sv
// Port checker of the two-wire slave
`timescale 1ns/1ps
`include "tsw_defs.svh"
module tsw_slave_assertions (
	input wire logic clk_sys_i,
	input wire logic rst_i,
	input wire logic scl_i,
	input wire logic sda_i,
	input wire logic sda_o,
	input wire logic sda_oe_o,
	input wire logic address_select_pin_i,
	input wire logic conv_req_o,
	input wire logic conv_done_i,
	input wire logic [`TSW_TEMP_W-1:0] conv_data_i,
	input wire logic [7:0] freq_sel_o,
	input wire logic [7:0] osc_ctrl_o,
	input wire logic [7:0] freq_tune_o
);
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (rst_i);
	chk_conv_runs: assert property (!rst_i |=> conv_req_o) else $error("request low");
	chk_oe_clk_low: assert property ($changed(sda_oe_o) |-> !scl_i && !$past(scl_i))
		else $error("drive moved near clock high");
	chk_ack_hold: assert property ($rose(sda_oe_o) |-> sda_oe_o [*5]) else $error("ack short");
	chk_pull_low: assert property (sda_oe_o |-> !sda_o) else $error("drives high");
	chk_stop_free: assert property (scl_i && $rose(sda_i) |-> !sda_oe_o [*4])
		else $error("drive after stop");
	chk_start_free: assert property (scl_i && $fell(sda_i) |=> !sda_oe_o [*3])
		else $error("drive at start");
	chk_sel_write: assert property ($changed(freq_sel_o) |-> !scl_i && !$past(scl_i, 2))
		else $error("select moved");
	chk_ctrl_write: assert property ($changed(osc_ctrl_o) |-> !scl_i && !$past(scl_i, 2))
		else $error("control moved");
	chk_tune_write: assert property ($changed(freq_tune_o) |-> !scl_i && !$past(scl_i, 2))
		else $error("tuning moved");
	cover property ($rose(sda_oe_o));
	cover property ($changed(osc_ctrl_o));
	cover property (scl_i && $rose(sda_i));
endmodule // tsw_slave_assertions

bind tsw_slave tsw_slave_assertions chk (.clk_sys_i, .rst_i, .scl_i, .sda_i, .sda_o, .sda_oe_o,
	.address_select_pin_i, .conv_req_o, .conv_done_i, .conv_data_i, .freq_sel_o, .osc_ctrl_o,
	.freq_tune_o);

// ### tb/testbench.sv
// Self-checking bench of the two-wire slave
`timescale 1ns/1ps
`include "tsw_defs.svh"
module testbench;
	logic clk_sys_i = 1'b0;
	logic rst_i = 1'b1;
	logic sel = 1'b0;
	logic done = 1'b0;
	logic [`TSW_TEMP_W-1:0] data = '0;
	logic scl, m_sda, sda_o, oe, req;
	logic [7:0] fsel, osc, tune;
	int err_total = 0;
	int n_checks = 0;
	wire sda = m_sda & ~(oe & ~sda_o);
	initial begin
		forever #25 clk_sys_i = ~clk_sys_i;
	end
	tsw_master_model m (.clk_i(clk_sys_i), .sda_i(sda), .scl_o(scl), .sda_o(m_sda));
	tsw_slave dut (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .scl_i(scl), .sda_i(sda), .sda_o(sda_o),
		.sda_oe_o(oe), .address_select_pin_i(sel), .conv_req_o(req), .conv_done_i(done),
		.conv_data_i(data), .freq_sel_o(fsel), .osc_ctrl_o(osc), .freq_tune_o(tune));
	task automatic chk(input string s, input logic [7:0] e, input logic [7:0] g);
		n_checks++;
		if (g !== e) begin
			err_total++;
			$display("Error %s expected %h seen %h", s, e, g);
		end
	endtask
	task automatic wr(input logic l, input logic [7:0] c, input logic [7:0] v, input logic ea);
		logic [7:0] q;
		logic a;
		m.cond(1'b1, 1'b0);
		m.xfer({`TSW_ADDR_BASE, l, 1'b0}, 1'b1, q, a);
		chk("address ack", {7'h00, ea}, {7'h00, a});
		m.xfer(c, 1'b1, q, a);
		chk("command ack", {7'h00, ea}, {7'h00, a});
		m.xfer(v, 1'b1, q, a);
		chk("data ack", {7'h00, ea}, {7'h00, a});
		m.cond(1'b0, 1'b1);
	endtask
	task automatic rd(input logic pc, input logic [7:0] c, input logic two, output logic [7:0] q1,
		output logic [7:0] q2);
		logic [7:0] q;
		logic a;
		q2 = 8'hff;
		m.cond(1'b1, 1'b0);
		if (pc) begin
			m.xfer({`TSW_ADDR_BASE, sel, 1'b0}, 1'b1, q, a);
			m.xfer(c, 1'b1, q, a);
			m.cond(1'b1, 1'b0);
		end
		m.xfer({`TSW_ADDR_BASE, sel, 1'b1}, 1'b1, q, a);
		m.xfer(8'hff, ~two, q1, a);
		if (two)
			m.xfer(8'hff, 1'b1, q2, a);
		m.cond(1'b0, 1'b1);
	endtask
	task automatic conv(input logic [`TSW_TEMP_W-1:0] v);
		@(negedge clk_sys_i) data = v;
		done = 1'b1;
		@(negedge clk_sys_i) done = 1'b0;
	endtask
	task automatic t_regs;
		logic [7:0] cmds [3] = '{8'h5d, 8'h60, 8'h66};
		logic [7:0] q1, q2;
		for (int i = 0; i < 3; i++) begin
			rd(1'b1, cmds[i], 1'b0, q1, q2);
			chk("reset value", 8'h00, q1);
			wr(1'b0, cmds[i], 8'ha5 ^ i[7:0], 1'b0);
			rd(1'b1, cmds[i], 1'b1, q1, q2);
			chk("readback", 8'ha5 ^ i[7:0], q1);
			chk("extra byte", 8'hff, q2);
		end
		chk("select out", 8'ha5, fsel);
		chk("control out", 8'ha4, osc);
		chk("tuning out", 8'ha7, tune);
		rd(1'b0, 8'h00, 1'b0, q1, q2);
		chk("pointer kept", 8'ha7, q1);
		rd(1'b1, 8'h42, 1'b0, q1, q2);
		chk("unknown command", 8'hff, q1);
	endtask
	task automatic t_temp;
		logic [7:0] q1, q2;
		conv(10'h3fe);
		rd(1'b1, `TSW_CMD_TEMP_HI, 1'b1, q1, q2);
		chk("minus half hi", 8'hff, q1);
		chk("minus half lo", 8'h80, q2);
		conv(10'h360);
		// New result lands mid-read and must not tear the pair
		fork
			rd(1'b1, `TSW_CMD_TEMP_HI, 1'b1, q1, q2);
			begin
				repeat (300) @(negedge clk_sys_i);
				conv(10'h1fd);
			end
		join
		chk("minus forty hi", 8'hd8, q1);
		chk("minus forty lo", 8'h00, q2);
		rd(1'b1, `TSW_CMD_TEMP_HI, 1'b0, q1, q2);
		chk("whole degrees", 8'h7f, q1);
		rd(1'b1, `TSW_CMD_TEMP_LO, 1'b0, q1, q2);
		chk("fraction", 8'h40, q1);
	endtask
	task automatic t_addr;
		sel = 1'b1;
		repeat (4) @(negedge clk_sys_i);
		wr(1'b0, 8'h5d, 8'h3c, 1'b1);
		chk("foreign write", 8'ha5, fsel);
		wr(1'b1, 8'h5d, 8'h3c, 1'b0);
		chk("own write", 8'h3c, fsel);
	endtask
	task automatic give_verdict;
		$display("checks %0d errors %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	initial begin
		repeat (3) @(negedge clk_sys_i);
		rst_i = 1'b0;
		repeat (4) @(negedge clk_sys_i);
		chk("conversion request", 8'h01, {7'h00, req});
		t_regs();
		t_temp();
		t_addr();
		give_verdict();
	end
endmodule // testbench
